// [hdl/sdram_ctrl.sv]
// Functional notes
// - Power-down request enters self-refresh, then acknowledges
// - Clearing request exits self-refresh, resumes operation
// - Mode-set writes MR0 value, bank from 15:14
// - Postpone mode defers refresh until limit exceeded
// - Postpone mode issues single refresh past limit
// - Normal mode refreshes when idle or above the limit, drains all
// - Initialize bit starts init, self-clears on start
// - Large memory bit enables over 512MByte
// - Uncorrectable error raises bus error when enabled
// - Correction raises bus error when enabled
// - Check code: lane 1 check, lane 0 data
// - Width bit selects 8-bit or 16-bit
// - Mode bit selects DDR2 or DDR3
// - Burst byte bit selects 8 or 16
// - Burst length bit selects four or eight beats
// - Initialization done status set on completion
// - Self-refresh acknowledge set once entered
// - Four-bit pending limit, reset 8, stalls accesses
`timescale 1ns/1ps
module sdram_ctrl (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Physical layer clock and data path status
    input wire logic phy_clk,
    input wire logic mem_idle,
    input wire logic ecc_err_in,
    input wire logic ecc_cor_in,
    // Memory command
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic [1:0] cmd_bank,
    output logic [15:0] cmd_addr,
    output logic cke,
    // Data path control
    output logic init_done,
    output logic access_stall,
    output logic bus_error,
    output logic [1:0] lane_enable,
    output logic check_code_active,
    output logic ddr3_mode,
    output logic burst_eight,
    output logic burst_sixteen_bytes,
    output logic large_memory_enable
);

    typedef enum logic [3:0] {
        ST_UNINIT,
        ST_INIT_WAIT,
        ST_INIT_PRE,
        ST_INIT_MRS,
        ST_INIT_REF,
        ST_IDLE,
        ST_MRS,
        ST_REFRESH,
        ST_SR_ENTER,
        ST_SR,
        ST_SR_EXIT,
        ST_SR_WAIT
    } state_t;

    typedef struct packed {
        state_t state;
        logic init_trigger;
        logic postpone;
        logic mrw_trigger;
        logic sr_request;
        logic [sdram_ctrl_pkg::CFG_MSB:0] cfg;
        logic [15:0] ref_period;
        logic [3:0] ref_limit;
        logic [15:0] init_delay;
        logic [3:0][15:0] mr;
        logic done;
        logic ack;
        logic err_seen;
        logic cor_seen;
        logic [15:0] wait_cnt;
        logic [1:0] step;
        logic [31:0] rdata;
        logic cmd_valid;
        sdram_ctrl_pkg::cmd_t cmd;
        logic [1:0] bank;
        logic [15:0] addr;
        logic cke;
        logic stall;
        logic bus_error;
        logic [1:0] lanes;
        logic ecc_on;
    } ctrl_t;

    ctrl_t st_r;
    ctrl_t st_nxt;
    logic phy_rise;
    logic ref_req;
    logic ref_over;
    logic ref_done;
    logic ecc_ok;
    logic [1:0] mr_pick;
    logic [31:0] rd_word;

    // Physical layer clock edge finder
    link_edge_sync u_phy_sync (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .pin(phy_clk),
        .rise(phy_rise)
    );

    // Refresh scheduler
    refresh_sched u_refresh (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .run(st_r.done),
        .postpone(st_r.postpone),
        .period(st_r.ref_period),
        .limit(st_r.ref_limit),
        .mem_idle(mem_idle),
        .done(ref_done),
        .req(ref_req),
        .over_limit(ref_over)
    );

    // Propagation bits may only hold while check code mode is written too
    assign ecc_ok = reg_wdata[sdram_ctrl_pkg::CFG_ECC_BIT];

    // Mode register order during initialization: 2, 3, 1, 0
    always_comb
    begin
        case (st_r.step)
            2'h0: mr_pick = 2'h2;
            2'h1: mr_pick = 2'h3;
            2'h2: mr_pick = 2'h1;
            default: mr_pick = 2'h0;
        endcase
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (reg_addr)
            sdram_ctrl_pkg::CTRL_OFS:
            begin
                rd_word[sdram_ctrl_pkg::CTRL_INIT_BIT] = st_r.init_trigger;
                rd_word[sdram_ctrl_pkg::CTRL_POSTPONE_BIT] = st_r.postpone;
                rd_word[sdram_ctrl_pkg::CTRL_MRW_BIT] = st_r.mrw_trigger;
                rd_word[sdram_ctrl_pkg::CTRL_SR_REQ_BIT] = st_r.sr_request;
            end
            sdram_ctrl_pkg::CFG_OFS: rd_word[sdram_ctrl_pkg::CFG_MSB:0] = st_r.cfg;
            sdram_ctrl_pkg::STAT_OFS:
            begin
                rd_word[sdram_ctrl_pkg::STAT_DONE_BIT] = st_r.done;
                rd_word[sdram_ctrl_pkg::STAT_ACK_BIT] = st_r.ack;
                rd_word[sdram_ctrl_pkg::STAT_COR_BIT] = st_r.cor_seen;
                rd_word[sdram_ctrl_pkg::STAT_ERR_BIT] = st_r.err_seen;
            end
            sdram_ctrl_pkg::REF_PERIOD_OFS:
                rd_word = {12'h000, st_r.ref_limit, st_r.ref_period};
            sdram_ctrl_pkg::TIMING2_OFS: rd_word = {16'h0000, st_r.init_delay};
            sdram_ctrl_pkg::MR0_OFS: rd_word = {16'h0000, st_r.mr[0]};
            sdram_ctrl_pkg::MR1_OFS: rd_word = {16'h0000, st_r.mr[1]};
            sdram_ctrl_pkg::MR2_OFS: rd_word = {16'h0000, st_r.mr[2]};
            sdram_ctrl_pkg::MR3_OFS: rd_word = {16'h0000, st_r.mr[3]};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Register writes, command sequencer and data path controls
    always_comb
    begin
        st_nxt = st_r;
        ref_done = 1'b0;
        st_nxt.cmd_valid = 1'b0;
        st_nxt.rdata = reg_rd ? rd_word : 32'h0000_0000;
        if (reg_wr)
        begin
            case (reg_addr)
                sdram_ctrl_pkg::CTRL_OFS:
                begin
                    st_nxt.init_trigger = st_r.init_trigger
                        | reg_wdata[sdram_ctrl_pkg::CTRL_INIT_BIT];
                    st_nxt.postpone = reg_wdata[sdram_ctrl_pkg::CTRL_POSTPONE_BIT];
                    st_nxt.mrw_trigger = st_r.mrw_trigger
                        | reg_wdata[sdram_ctrl_pkg::CTRL_MRW_BIT];
                    st_nxt.sr_request = reg_wdata[sdram_ctrl_pkg::CTRL_SR_REQ_BIT];
                end
                sdram_ctrl_pkg::CFG_OFS:
                begin
                    st_nxt.cfg = reg_wdata[sdram_ctrl_pkg::CFG_MSB:0];
                    st_nxt.cfg[sdram_ctrl_pkg::CFG_ERR_PROP_BIT] = ecc_ok
                        & reg_wdata[sdram_ctrl_pkg::CFG_ERR_PROP_BIT];
                    st_nxt.cfg[sdram_ctrl_pkg::CFG_COR_PROP_BIT] = ecc_ok
                        & reg_wdata[sdram_ctrl_pkg::CFG_COR_PROP_BIT];
                end
                sdram_ctrl_pkg::STAT_OFS:
                begin
                    // Write one clears a sticky flag
                    if (reg_wdata[sdram_ctrl_pkg::STAT_COR_BIT])
                        st_nxt.cor_seen = 1'b0;
                    if (reg_wdata[sdram_ctrl_pkg::STAT_ERR_BIT])
                        st_nxt.err_seen = 1'b0;
                end
                sdram_ctrl_pkg::REF_PERIOD_OFS:
                begin
                    st_nxt.ref_period = reg_wdata[sdram_ctrl_pkg::REF_PERIOD_LSB +: 16];
                    st_nxt.ref_limit = reg_wdata[sdram_ctrl_pkg::REF_LIMIT_LSB +: 4];
                end
                sdram_ctrl_pkg::TIMING2_OFS: st_nxt.init_delay = reg_wdata[15:0];
                sdram_ctrl_pkg::MR0_OFS: st_nxt.mr[0] = reg_wdata[15:0];
                sdram_ctrl_pkg::MR1_OFS: st_nxt.mr[1] = reg_wdata[15:0];
                sdram_ctrl_pkg::MR2_OFS: st_nxt.mr[2] = reg_wdata[15:0];
                sdram_ctrl_pkg::MR3_OFS: st_nxt.mr[3] = reg_wdata[15:0];
                default: st_nxt.rdata = st_nxt.rdata;
            endcase
        end
        case (st_r.state)
            ST_UNINIT, ST_IDLE:
            begin
                if (st_r.init_trigger)
                begin
                    st_nxt.init_trigger = 1'b0;
                    st_nxt.done = 1'b0;
                    st_nxt.cke = 1'b0;
                    st_nxt.wait_cnt = st_r.init_delay;
                    st_nxt.state = ST_INIT_WAIT;
                end
                else if (st_r.state == ST_IDLE)
                begin
                    if (ref_req)
                        st_nxt.state = ST_REFRESH;
                    else if (st_r.mrw_trigger)
                        st_nxt.state = ST_MRS;
                    else if (st_r.sr_request)
                        st_nxt.state = ST_SR_ENTER;
                end
            end
            ST_INIT_WAIT:
            begin
                if (st_r.wait_cnt == 16'h0000)
                begin
                    st_nxt.cke = 1'b1;
                    st_nxt.step = 2'h0;
                    st_nxt.state = ST_INIT_PRE;
                end
                else
                    st_nxt.wait_cnt = st_r.wait_cnt - 16'h0001;
            end
            ST_INIT_PRE:
            begin
                if (phy_rise)
                begin
                    st_nxt.cmd_valid = 1'b1;
                    st_nxt.cmd = sdram_ctrl_pkg::CMD_PRECHARGE_ALL;
                    st_nxt.state = ST_INIT_MRS;
                end
            end
            ST_INIT_MRS:
            begin
                if (phy_rise)
                begin
                    st_nxt.cmd_valid = 1'b1;
                    st_nxt.cmd = sdram_ctrl_pkg::CMD_MODE_WRITE;
                    st_nxt.bank = mr_pick;
                    st_nxt.addr = st_r.mr[mr_pick];
                    st_nxt.step = st_r.step + 2'h1;
                    if (st_r.step == 2'h3)
                        st_nxt.state = ST_INIT_REF;
                end
            end
            ST_INIT_REF:
            begin
                if (phy_rise)
                begin
                    st_nxt.cmd_valid = 1'b1;
                    st_nxt.cmd = sdram_ctrl_pkg::CMD_REFRESH;
                    st_nxt.done = 1'b1;
                    st_nxt.state = ST_IDLE;
                end
            end
            ST_MRS:
            begin
                if (phy_rise)
                begin
                    st_nxt.cmd_valid = 1'b1;
                    st_nxt.cmd = sdram_ctrl_pkg::CMD_MODE_WRITE;
                    st_nxt.bank = st_r.mr[0][15:14];
                    st_nxt.addr = st_r.mr[0];
                    st_nxt.mrw_trigger = reg_wr && reg_addr == sdram_ctrl_pkg::CTRL_OFS
                        && reg_wdata[sdram_ctrl_pkg::CTRL_MRW_BIT];
                    st_nxt.state = ST_IDLE;
                end
            end
            ST_REFRESH:
            begin
                if (phy_rise)
                begin
                    st_nxt.cmd_valid = 1'b1;
                    st_nxt.cmd = sdram_ctrl_pkg::CMD_REFRESH;
                    ref_done = 1'b1;
                    st_nxt.state = ST_IDLE;
                end
            end
            ST_SR_ENTER:
            begin
                if (phy_rise)
                begin
                    st_nxt.cmd_valid = 1'b1;
                    st_nxt.cmd = sdram_ctrl_pkg::CMD_SELF_REF_ENTER;
                    st_nxt.cke = 1'b0;
                    st_nxt.ack = 1'b1;
                    st_nxt.state = ST_SR;
                end
            end
            ST_SR:
            begin
                if (!st_r.sr_request)
                    st_nxt.state = ST_SR_EXIT;
            end
            ST_SR_EXIT:
            begin
                if (phy_rise)
                begin
                    st_nxt.cmd_valid = 1'b1;
                    st_nxt.cmd = sdram_ctrl_pkg::CMD_SELF_REF_EXIT;
                    st_nxt.cke = 1'b1;
                    st_nxt.ack = 1'b0;
                    st_nxt.wait_cnt = st_r.init_delay;
                    st_nxt.state = ST_SR_WAIT;
                end
            end
            ST_SR_WAIT:
            begin
                if (st_r.wait_cnt == 16'h0000)
                    st_nxt.state = ST_IDLE;
                else
                    st_nxt.wait_cnt = st_r.wait_cnt - 16'h0001;
            end
            default: st_nxt.state = ST_UNINIT;
        endcase
        // Check code only takes effect on a 16-bit interface
        st_nxt.ecc_on = st_r.cfg[sdram_ctrl_pkg::CFG_ECC_BIT]
            & st_r.cfg[sdram_ctrl_pkg::CFG_WIDTH_BIT];
        st_nxt.lanes = {st_r.cfg[sdram_ctrl_pkg::CFG_WIDTH_BIT], 1'b1};
        // Error events; a new event wins over a clear in the same cycle
        if (st_r.ecc_on && ecc_err_in)
            st_nxt.err_seen = 1'b1;
        if (st_r.ecc_on && ecc_cor_in)
            st_nxt.cor_seen = 1'b1;
        st_nxt.bus_error = st_r.ecc_on
            & ((ecc_err_in & st_r.cfg[sdram_ctrl_pkg::CFG_ERR_PROP_BIT])
            | (ecc_cor_in & st_r.cfg[sdram_ctrl_pkg::CFG_COR_PROP_BIT]));
        // Data accesses wait while not idle or above the pending limit
        st_nxt.stall = (st_nxt.state != ST_IDLE) | ref_over | !st_nxt.done;
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.state <= ST_UNINIT;
            st_r.ref_period <= sdram_ctrl_pkg::REF_PERIOD_RST;
            st_r.ref_limit <= sdram_ctrl_pkg::REF_LIMIT_RST;
            st_r.init_delay <= sdram_ctrl_pkg::INITIALIZATION_DELAY_RST;
            st_r.cmd <= sdram_ctrl_pkg::CMD_NOP;
            st_r.stall <= 1'b1;
            st_r.lanes <= 2'h1;
        end
        else if (ce)
            st_r <= st_nxt;
    end

    // Outputs straight from the state register
    assign reg_rdata = st_r.rdata;
    assign cmd_valid = st_r.cmd_valid;
    assign cmd_code = st_r.cmd;
    assign cmd_bank = st_r.bank;
    assign cmd_addr = st_r.addr;
    assign cke = st_r.cke;
    assign init_done = st_r.done;
    assign access_stall = st_r.stall;
    assign bus_error = st_r.bus_error;
    assign lane_enable = st_r.lanes;
    assign check_code_active = st_r.ecc_on;
    assign ddr3_mode = st_r.cfg[sdram_ctrl_pkg::CFG_MODE_BIT];
    assign burst_eight = st_r.cfg[sdram_ctrl_pkg::CFG_BURST_BEAT_LENGTH_BIT];
    assign burst_sixteen_bytes = st_r.cfg[sdram_ctrl_pkg::CFG_BURST_BYTES_BIT];
    assign large_memory_enable = st_r.cfg[sdram_ctrl_pkg::CFG_LARGE_BIT];

endmodule // sdram_ctrl

// [hdl/sdram_ctrl_pkg.sv]
package sdram_ctrl_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CFG_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] REF_PERIOD_OFS = 8'h0c;
    localparam logic [7:0] TIMING2_OFS = 8'h1c;
    localparam logic [7:0] MR0_OFS = 8'h28;
    localparam logic [7:0] MR1_OFS = 8'h2c;
    localparam logic [7:0] MR2_OFS = 8'h30;
    localparam logic [7:0] MR3_OFS = 8'h34;

    // Control register fields
    localparam int CTRL_INIT_BIT = 0;
    localparam int CTRL_POSTPONE_BIT = 1;
    localparam int CTRL_MRW_BIT = 2;
    localparam int CTRL_SR_REQ_BIT = 3;

    // Configuration register fields
    localparam int CFG_BURST_BEAT_LENGTH_BIT = 9;
    localparam int CFG_BURST_BYTES_BIT = 10;
    localparam int CFG_MODE_BIT = 11;
    localparam int CFG_WIDTH_BIT = 12;
    localparam int CFG_ECC_BIT = 13;
    localparam int CFG_COR_PROP_BIT = 14;
    localparam int CFG_ERR_PROP_BIT = 15;
    localparam int CFG_LARGE_BIT = 16;
    localparam int CFG_MSB = 16;

    // Status register fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_ACK_BIT = 1;
    localparam int STAT_COR_BIT = 2;
    localparam int STAT_ERR_BIT = 3;

    // Refresh period register fields
    localparam int REF_PERIOD_LSB = 0;
    localparam int REF_LIMIT_LSB = 16;

    // Reset values
    localparam logic [15:0] REF_PERIOD_RST = 16'h0100;
    localparam logic [3:0] REF_LIMIT_RST = 4'h8;
    localparam logic [15:0] INITIALIZATION_DELAY_RST = 16'h0100;

    // Memory commands toward the physical layer
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_PRECHARGE_ALL,
        CMD_REFRESH,
        CMD_MODE_WRITE,
        CMD_SELF_REF_ENTER,
        CMD_SELF_REF_EXIT
    } cmd_t;

endpackage

// [hdl/link_edge_sync.sv]
`timescale 1ns/1ps
module link_edge_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Asynchronous input and its rising edge
    input wire logic pin,
    output logic rise
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    // Shift chain; a change counts once stages two and three agree
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.rise = 1'b0;
        if (st_r.s2 == st_r.s3 && st_r.s3 != st_r.level)
        begin
            st_nxt.level = st_r.s3;
            st_nxt.rise = st_r.s3;
        end
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (rst)
            st_r <= '0;
        else if (ce)
            st_r <= st_nxt;
    end

    assign rise = st_r.rise;

endmodule // link_edge_sync

// [hdl/refresh_sched.sv]
`timescale 1ns/1ps
module refresh_sched (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Settings
    input wire logic run,
    input wire logic postpone,
    input wire logic [15:0] period,
    input wire logic [3:0] limit,
    // Handshake with the command sequencer
    input wire logic mem_idle,
    input wire logic done,
    output logic req,
    output logic over_limit
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [4:0] pend;
        logic drain;
    } sched_t;

    sched_t st_r;
    sched_t st_nxt;
    logic tick;

    // Period counter, pending count and drain mode
    always_comb
    begin
        st_nxt = st_r;
        tick = run && st_r.cnt == 16'h0000;
        st_nxt.cnt = (!run || tick) ? period : st_r.cnt - 16'h0001;
        if (tick && !done && st_r.pend != 5'h1f)
            st_nxt.pend = st_r.pend + 5'h01;
        else if (done && !tick && st_r.pend != 5'h00)
            st_nxt.pend = st_r.pend - 5'h01;
        if (postpone || st_r.pend == 5'h00)
            st_nxt.drain = 1'b0;
        else if (mem_idle || over_limit)
            st_nxt.drain = 1'b1;
        if (!run)
            st_nxt = '{cnt: period, pend: 5'h00, drain: 1'b0};
    end

    // Postponed mode asks only above the limit, and one at a time
    assign over_limit = st_r.pend > {1'b0, limit};
    assign req = postpone ? over_limit : (st_r.drain && st_r.pend != 5'h00);

    // State register
    always_ff @(posedge core_clk)
    begin
        if (rst)
            st_r <= '{cnt: sdram_ctrl_pkg::REF_PERIOD_RST, pend: 5'h00, drain: 1'b0};
        else if (ce)
            st_r <= st_nxt;
    end

endmodule // refresh_sched

// [tb/sdram_ctrl_checker.sv]
`timescale 1ns/1ps
module sdram_ctrl_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Watched ports
    input wire logic ecc_err_in,
    input wire logic ecc_cor_in,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [1:0] cmd_bank,
    input wire logic [15:0] cmd_addr,
    input wire logic cke,
    input wire logic init_done,
    input wire logic access_stall,
    input wire logic bus_error,
    input wire logic [1:0] lane_enable,
    input wire logic check_code_active
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Command framing, clock enable and data path relations
    property p_sr_enter;
        cmd_valid && cmd_code == sdram_ctrl_pkg::CMD_SELF_REF_ENTER |-> !cke;
    endproperty
    a_sr_enter: assert property (p_sr_enter) else $error("cke high in self-refresh");
    property p_sr_exit;
        cmd_valid && cmd_code == sdram_ctrl_pkg::CMD_SELF_REF_EXIT |-> cke;
    endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("cke low after exit");
    property p_hold;
        !cmd_valid |-> $stable(cmd_bank) && $stable(cmd_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("mode target moved");
    property p_single;
        cmd_valid |=> !cmd_valid [*3];
    endproperty
    a_single: assert property (p_single) else $error("commands too close");
    property p_lane0;
        lane_enable[0];
    endproperty
    a_lane0: assert property (p_lane0) else $error("lane 0 off");
    property p_check_lanes;
        check_code_active |-> lane_enable == 2'b11;
    endproperty
    a_check_lanes: assert property (p_check_lanes) else $error("check lane off");
    property p_err_cause;
        bus_error |-> $past(check_code_active) && $past(ecc_err_in || ecc_cor_in);
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("stray bus error");
    property p_no_err;
        (ecc_err_in || ecc_cor_in) && !check_code_active |=> !bus_error;
    endproperty
    a_no_err: assert property (p_no_err) else $error("error without check mode");
    property p_done_ref;
        $rose(init_done) |-> cmd_valid && cmd_code == sdram_ctrl_pkg::CMD_REFRESH;
    endproperty
    a_done_ref: assert property (p_done_ref) else $error("done without refresh");
    property p_stall;
        !init_done |-> access_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("access open before init");
endmodule // sdram_ctrl_checker

bind sdram_ctrl sdram_ctrl_checker sdram_ctrl_checker_inst (.core_clk, .rst, .ecc_err_in,
    .ecc_cor_in, .cmd_valid, .cmd_code, .cmd_bank, .cmd_addr, .cke, .init_done,
    .access_stall, .bus_error, .lane_enable, .check_code_active);

// [tb/sdram_dev_model.sv]
`timescale 1ns/1ps
module sdram_dev_model (
    // Command side
    input wire logic core_clk,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    // Memory clock and counts
    output logic phy_clk,
    output int n_ref,
    output int n_mrw
);
    // Free-running memory clock, phase unrelated to the core
    initial
    begin
        phy_clk = 1'b0;
        #37;
        forever #100 phy_clk = ~phy_clk;
    end
    // Count refresh and mode writes seen by the memory
    initial
    begin
        n_ref = 0;
        n_mrw = 0;
    end
    always @(posedge core_clk)
    begin
        if (cmd_valid && cmd_code == sdram_ctrl_pkg::CMD_REFRESH)
            n_ref <= n_ref + 1;
        if (cmd_valid && cmd_code == sdram_ctrl_pkg::CMD_MODE_WRITE)
            n_mrw <= n_mrw + 1;
    end
endmodule // sdram_dev_model

// [tb/ddr_sdram_ctrl_config_tb_top.sv]
`timescale 1ns/1ps
module ddr_sdram_ctrl_config_tb_top;
    logic core_clk, rst, ce, reg_wr, reg_rd, mem_idle, ecc_err_in, ecc_cor_in, phy_clk;
    logic cmd_valid, cke, init_done, access_stall, bus_error, check_code_active;
    logic ddr3_mode, burst_eight, burst_sixteen_bytes, large_memory_enable;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0] cmd_code;
    logic [1:0] cmd_bank, lane_enable;
    logic [15:0] cmd_addr;
    logic [15:0] mr[4];
    logic [16:0] seed;
    int n_mismatch, tests_run, n_cyc, n_ref, n_mrw, r0;
    int q[$];

    sdram_ctrl sdram_ctrl_inst (.core_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .phy_clk, .mem_idle, .ecc_err_in, .ecc_cor_in, .cmd_valid,
        .cmd_code, .cmd_bank, .cmd_addr, .cke, .init_done, .access_stall, .bus_error,
        .lane_enable, .check_code_active, .ddr3_mode, .burst_eight, .burst_sixteen_bytes,
        .large_memory_enable);
    sdram_dev_model sdram_dev_model_inst (.core_clk, .cmd_valid, .cmd_code, .phy_clk,
        .n_ref, .n_mrw);

    // Core clock
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    function automatic logic [16:0] lfsr(logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdchk(logic [7:0] a, logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, reg_rdata);
        @(posedge core_clk);
    endtask
    task automatic ecc(bit e, logic exp);
        ecc_err_in <= e;
        ecc_cor_in <= !e;
        @(posedge core_clk);
        ecc_err_in <= 1'b0;
        ecc_cor_in <= 1'b0;
        @(negedge core_clk);
        chk("bus_error", {31'h0, exp}, {31'h0, bus_error});
        @(posedge core_clk);
    endtask
    task automatic sett(int n);
        for (int i = 0; i < n; i++)
            @(posedge core_clk);
    endtask

    // Hang guard
    always @(posedge core_clk)
    begin
        n_cyc++;
        if (n_cyc == 20000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    // Main sequence
    initial
    begin
        {rst, ce, reg_wr, reg_rd, mem_idle, ecc_err_in, ecc_cor_in} = 7'h64;
        {reg_addr, reg_wdata, n_mismatch, tests_run, n_cyc} = '0;
        seed = 17'd95802;
        sett(4);
        rst <= 1'b0;
        q = '{0, 0, 0, {12'h0, sdram_ctrl_pkg::REF_LIMIT_RST, sdram_ctrl_pkg::REF_PERIOD_RST},
            sdram_ctrl_pkg::INITIALIZATION_DELAY_RST, 0};
        foreach (q[i])
            rdchk(8'(i < 5 ? 4 * i + (i == 4 ? 12 : 0) : 8'h40), q[i]);
        chk("outs", 7'h02, {large_memory_enable, ddr3_mode, burst_eight, burst_sixteen_bytes,
            lane_enable, check_code_active});
        wr(sdram_ctrl_pkg::REF_PERIOD_OFS, 32'h00020040);
        wr(sdram_ctrl_pkg::TIMING2_OFS, 32'h10);
        for (int k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            mr[k] = {2'(k + 1), seed[13:0]};
            wr(sdram_ctrl_pkg::MR0_OFS + 8'(4 * k), {16'h0, mr[k]});
        end
        wr(sdram_ctrl_pkg::CFG_OFS, 32'hc000);
        rdchk(sdram_ctrl_pkg::CFG_OFS, 0);
        wr(sdram_ctrl_pkg::CFG_OFS, 32'h1fe00);
        rdchk(sdram_ctrl_pkg::CFG_OFS, 32'h1fe00);
        chk("outs", 7'h7f, {large_memory_enable, ddr3_mode, burst_eight, burst_sixteen_bytes,
            lane_enable, check_code_active});
        wr(sdram_ctrl_pkg::CTRL_OFS, 1);
        rdchk(sdram_ctrl_pkg::CTRL_OFS, 0);
        for (int i = 0; i < 900 && !init_done; i++)
            @(negedge core_clk);
        @(posedge core_clk);
        rdchk(sdram_ctrl_pkg::STAT_OFS, 1);
        chk("init mrw", 4, n_mrw);
        wr(sdram_ctrl_pkg::CTRL_OFS, 4);
        for (int i = 0; i < 300 && n_mrw < 5; i++)
            @(negedge core_clk);
        chk("mrw", {mr[0][15:14], mr[0]}, {cmd_bank, cmd_addr});
        @(posedge core_clk);
        rdchk(sdram_ctrl_pkg::CTRL_OFS, 0);
        seed = lfsr(seed);
        ecc(seed[0], 1'b1);
        ecc(!seed[0], 1'b1);
        rdchk(sdram_ctrl_pkg::STAT_OFS, 32'hd);
        wr(sdram_ctrl_pkg::STAT_OFS, 32'hc);
        wr(sdram_ctrl_pkg::CTRL_OFS, 8);
        for (int i = 0; i < 300 && cke; i++)
            @(negedge core_clk);
        @(posedge core_clk);
        rdchk(sdram_ctrl_pkg::STAT_OFS, 3);
        wr(sdram_ctrl_pkg::CTRL_OFS, 0);
        for (int i = 0; i < 300 && access_stall; i++)
            @(negedge core_clk);
        chk("cke", 1, cke);
        @(posedge core_clk);
        rdchk(sdram_ctrl_pkg::STAT_OFS, 1);
        r0 = n_ref;
        for (int i = 0; i < 300 && n_ref == r0; i++)
            @(negedge core_clk);
        sett(20);
        wr(sdram_ctrl_pkg::CTRL_OFS, 2);
        r0 = n_ref;
        sett(100);
        chk("postponed", r0, n_ref);
        for (int i = 0; i < 300 && n_ref == r0; i++)
            @(negedge core_clk);
        @(posedge core_clk);
        sett(30);
        chk("single", r0 + 1, n_ref);
        wr(sdram_ctrl_pkg::CTRL_OFS, 0);
        sett(30);
        chk("drain", 1, (n_ref - r0) >= 3);
        wr(sdram_ctrl_pkg::CFG_OFS, 32'h1000);
        ecc(seed[1], 1'b0);
        close_out();
    end
endmodule // ddr_sdram_ctrl_config_tb_top
